// ---- inc/psir_defs.svh ----
// Constants for the port status and first identifier register block
`ifndef PSIR_DEFS_SVH
`define PSIR_DEFS_SVH

// ----------------------------------------------------------------------------
// Register addresses and frame fields
// ----------------------------------------------------------------------------
`define PSIR_REG_STATUS   5'h01
`define PSIR_REG_ID1      5'h02
`define PSIR_OP_READ      2'h2
`define PSIR_ADDR_LAST    5'h04
`define PSIR_TA_LAST      5'h01
`define PSIR_DATA_LAST    5'h0F
`define PSIR_PRE_FIRST    6'h20
`define PSIR_PRE_NEXT     6'h01

// ----------------------------------------------------------------------------
// Status word field positions and fixed values
// ----------------------------------------------------------------------------
`define PSIR_ST_T4        15
`define PSIR_ST_CAP_HI    14
`define PSIR_ST_CAP_LO    11
`define PSIR_ST_RSV_HI    10
`define PSIR_ST_RSV_LO    7
`define PSIR_ST_PRE       6
`define PSIR_ST_ANC       5
`define PSIR_ST_RF        4
`define PSIR_ST_ANA       3
`define PSIR_ST_LINK      2
`define PSIR_ST_JAB       1
`define PSIR_ST_EXT       0
`define PSIR_T4_VAL       1'h0
`define PSIR_CAP_VAL      4'hF
`define PSIR_RSV_VAL      4'h0
`define PSIR_PRE_VAL      1'h1
`define PSIR_ANA_VAL      1'h1
`define PSIR_EXT_VAL      1'h1

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PSIR_CLK_KHZ      100000
`define PSIR_JABBER_MS    21
`define PSIR_RECOVER_MS   500
`define PSIR_BLINK_MS     50

`endif

// ---- inc/psir_pkg.sv ----
// Types and shared decode for the port status and first identifier registers
`default_nettype none
`include "psir_defs.svh"

package psir_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_OPC   = 3'h3,
    ST_PHYAD = 3'h2,
    ST_REGAD = 3'h6,
    ST_TA    = 3'h7,
    ST_DATA  = 3'h5
  } psir_state_t;

  typedef enum logic [1:0] {
    REG_NONE   = 2'h0,
    REG_STATUS = 2'h1,
    REG_ID1    = 2'h2
  } psir_reg_t;

  function automatic psir_reg_t psir_reg_sel(input logic [4:0] addr);
    if (addr == `PSIR_REG_STATUS) begin
      return REG_STATUS;
    end else if (addr == `PSIR_REG_ID1) begin
      return REG_ID1;
    end else begin
      return REG_NONE;
    end
  endfunction

endpackage
`default_nettype wire

// ---- rtl/psir_mdio_rx.sv ----
// Serial management frame engine: pin sampling, frame decode and read drive
`timescale 1ns/10ps
`default_nettype none
`include "psir_defs.svh"

module psir_mdio_rx #(
  parameter logic [4:0] P_PHY_ADDR = 5'h00
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Management pins
  input  wire logic        i_mdc,
  input  wire logic        i_mdio_in,
  output logic             o_mdio_out,
  output logic             o_mdio_oe,
  // Register read side
  input  wire logic [15:0] i_rd_data,
  output logic [4:0]       o_rd_addr,
  output logic             o_rd_load,
  output logic             o_rd_done
);

  // --------------------------------------------------------------------------
  // Pin synchronisers and clock edge detect
  // --------------------------------------------------------------------------
  logic                  mdc_meta_r;
  logic                  mdc_sync_r;
  logic                  mdc_prev_r;
  logic                  mdio_meta_r;
  logic                  mdio_sync_r;
  logic                  mdc_rise;
  logic                  bit_in;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mdc_meta_r  <= 1'b0;
      mdc_sync_r  <= 1'b0;
      mdc_prev_r  <= 1'b0;
      mdio_meta_r <= 1'b1;
      mdio_sync_r <= 1'b1;
    end else begin
      mdc_meta_r  <= i_mdc;
      mdc_sync_r  <= mdc_meta_r;
      mdc_prev_r  <= mdc_sync_r;
      mdio_meta_r <= i_mdio_in;
      mdio_sync_r <= mdio_meta_r;
    end
  end

  assign mdc_rise = mdc_sync_r & ~mdc_prev_r;
  assign bit_in   = mdio_sync_r;

  // --------------------------------------------------------------------------
  // Frame decoder
  // --------------------------------------------------------------------------
  psir_pkg::psir_state_t state_r;
  logic [4:0]            cnt_r;
  logic [5:0]            ones_r;
  logic                  first_done_r;
  logic [1:0]            op_r;
  logic [4:0]            phy_r;
  logic [4:0]            addr_r;
  logic                  rd_sel_r;
  logic [5:0]            ones_need;
  logic [4:0]            addr_full;
  logic                  rd_sel_nxt;
  logic [15:0]           shift_r;

  // Full preamble once after reset, then only the idle bit before a start
  assign ones_need  = first_done_r ? `PSIR_PRE_NEXT : `PSIR_PRE_FIRST; // see [RQ5]
  assign addr_full  = {addr_r[3:0], bit_in};
  assign rd_sel_nxt = (op_r == `PSIR_OP_READ) && (phy_r == P_PHY_ADDR) &&
                      (psir_pkg::psir_reg_sel(addr_full) != psir_pkg::REG_NONE);
  assign o_rd_addr  = addr_r;
  assign o_rd_load  = mdc_rise && (state_r == psir_pkg::ST_TA) &&
                      (cnt_r == `PSIR_TA_LAST) && rd_sel_r;
  assign o_rd_done  = mdc_rise && (state_r == psir_pkg::ST_DATA) &&
                      (cnt_r == 5'h00) && rd_sel_r; // see [RQ22]

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r      <= psir_pkg::ST_IDLE;
      cnt_r        <= 5'h00;
      ones_r       <= 6'h00;
      first_done_r <= 1'b0;
      op_r         <= 2'h0;
      phy_r        <= 5'h00;
      addr_r       <= 5'h00;
      rd_sel_r     <= 1'b0;
    end else if (mdc_rise) begin
      case (state_r)
        psir_pkg::ST_IDLE: begin
          if (bit_in) begin
            if (ones_r != `PSIR_PRE_FIRST) begin
              ones_r <= ones_r + 6'h01;
            end
          end else begin
            if (ones_r >= ones_need) begin
              state_r <= psir_pkg::ST_START;
            end
            ones_r <= 6'h00;
          end
        end
        psir_pkg::ST_START: begin
          if (bit_in) begin
            state_r      <= psir_pkg::ST_OPC;
            cnt_r        <= `PSIR_TA_LAST;
            first_done_r <= 1'b1;
          end else begin
            state_r <= psir_pkg::ST_IDLE;
          end
        end
        psir_pkg::ST_OPC: begin
          op_r <= {op_r[0], bit_in};
          if (cnt_r == 5'h00) begin
            state_r <= psir_pkg::ST_PHYAD;
            cnt_r   <= `PSIR_ADDR_LAST;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        psir_pkg::ST_PHYAD: begin
          phy_r <= {phy_r[3:0], bit_in};
          if (cnt_r == 5'h00) begin
            state_r <= psir_pkg::ST_REGAD;
            cnt_r   <= `PSIR_ADDR_LAST;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        psir_pkg::ST_REGAD: begin
          addr_r <= addr_full;
          if (cnt_r == 5'h00) begin
            state_r  <= psir_pkg::ST_TA;
            cnt_r    <= `PSIR_TA_LAST;
            rd_sel_r <= rd_sel_nxt;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        psir_pkg::ST_TA: begin
          if (cnt_r == 5'h00) begin
            state_r <= psir_pkg::ST_DATA;
            cnt_r   <= `PSIR_DATA_LAST;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        psir_pkg::ST_DATA: begin
          if (cnt_r == 5'h00) begin
            state_r  <= psir_pkg::ST_IDLE;
            rd_sel_r <= 1'b0;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        default: begin
          state_r <= psir_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Data pin driver: zero in second turnaround bit, then sixteen data bits
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mdio_out <= 1'b0;
      o_mdio_oe  <= 1'b0;
      shift_r    <= 16'h0000;
    end else if (mdc_rise) begin
      if (o_rd_load) begin
        shift_r    <= i_rd_data;
        o_mdio_oe  <= 1'b1;
        o_mdio_out <= 1'b0;
      end else if (rd_sel_r && (state_r == psir_pkg::ST_TA ||
                   (state_r == psir_pkg::ST_DATA && cnt_r != 5'h00))) begin
        o_mdio_out <= shift_r[15];
        shift_r    <= {shift_r[14:0], 1'b0};
      end else if (state_r == psir_pkg::ST_DATA && cnt_r == 5'h00) begin
        o_mdio_oe  <= 1'b0;
        o_mdio_out <= 1'b0;
      end
    end
  end

endmodule // psir_mdio_rx
`default_nettype wire

// ---- rtl/psir_status_regs.sv ----
// Port status and first identifier registers behind the management pins
// Functional notes
// [RQ1] Four-pair 100 Mb flag always reads zero
// [RQ2] Bits 14..11 read one, read-only
// [RQ3] Reserved bits 10..7 read zero, host ignores
// [RQ4] Preamble-optional flag bit 6 always one
// [RQ5] Frames accepted with or without preamble
// [RQ6] Host sends 32 preamble bits after reset
// [RQ7] Host leaves one idle bit between frames
// [RQ8] Bit 5 shows auto-negotiation complete
// [RQ9] Bit 4 sets on far-end fault indication
// [RQ10] Remote fault stays high until status read
// [RQ11] Auto-negotiation ability bit always one
// [RQ12] Bit 2 shows link pass state
// [RQ13] Link failure latches bit 2 low until read
// [RQ14] Jabber bit latches in 10 Mb only
// [RQ15] Transmit over 21 ms cuts transmit, blinks LED
// [RQ16] 500 ms idle transmit restores, LED stops
// [RQ17] Extended capability bit always one
// [RQ18] Identifier word holds fixed identifier bits
// [RQ19] Two identifier words form 32-bit identifier
// [RQ20] Registers reached over two-wire management pins
// [RQ21] Fiber mode forces negotiation off, 100 Mb
// [RQ22] Read side effects only on complete reads
`timescale 1ns/10ps
`default_nettype none
`include "psir_defs.svh"

module psir_status_regs #(
  parameter logic [4:0]  P_PHY_ADDR    = 5'h00,
  // Arbitrary neutral identifier value
  parameter logic [15:0] P_OUI_ID1     = 16'hA5C3,
  parameter int          P_CNT_W       = 26,
  parameter int          P_JABBER_CYC  = `PSIR_JABBER_MS * `PSIR_CLK_KHZ,
  parameter int          P_RECOVER_CYC = `PSIR_RECOVER_MS * `PSIR_CLK_KHZ,
  parameter int          P_BLINK_CYC   = `PSIR_BLINK_MS * `PSIR_CLK_KHZ
) (
  // Clock and resets
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_soft_rst,
  // Management pins
  input  wire logic i_mdc,
  input  wire logic i_mdio_in,
  output logic      o_mdio_out,
  output logic      o_mdio_oe,
  // Port core status
  input  wire logic i_link_pass,
  input  wire logic i_an_complete,
  input  wire logic i_far_end_fault,
  input  wire logic i_speed_100,
  input  wire logic i_fiber_100_mode,
  // Transmit enable pin from the MAC
  input  wire logic i_tx_en,
  // Port controls
  output logic      o_tx_inhibit,
  output logic      o_loopback_inhibit,
  output logic      o_collision_indicator_led,
  output logic      o_an_force_off,
  output logic      o_speed_100_rpt
);

  localparam logic [P_CNT_W-1:0] L_JAB_CYC   = P_CNT_W'(P_JABBER_CYC);
  localparam logic [P_CNT_W-1:0] L_REC_CYC   = P_CNT_W'(P_RECOVER_CYC);
  localparam logic [P_CNT_W-1:0] L_BLINK_CYC = P_CNT_W'(P_BLINK_CYC);

  // --------------------------------------------------------------------------
  // Management frame engine
  // --------------------------------------------------------------------------
  logic [15:0]         rd_word;
  logic [4:0]          rd_addr;
  logic                rd_load;
  logic                rd_done;
  psir_pkg::psir_reg_t rd_reg;

  psir_mdio_rx #(
    .P_PHY_ADDR (P_PHY_ADDR)
  ) u_mdio_rx (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_mdc      (i_mdc),
    .i_mdio_in  (i_mdio_in),
    .o_mdio_out (o_mdio_out),
    .o_mdio_oe  (o_mdio_oe),
    .i_rd_data  (rd_word),
    .o_rd_addr  (rd_addr),
    .o_rd_load  (rd_load),
    .o_rd_done  (rd_done)
  ); // see [RQ20]

  assign rd_reg = psir_pkg::psir_reg_sel(rd_addr);

  // --------------------------------------------------------------------------
  // Transmit enable synchroniser and mode decode
  // --------------------------------------------------------------------------
  logic tx_meta_r;
  logic tx_en_s;
  logic mode10;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_meta_r <= 1'b0;
      tx_en_s   <= 1'b0;
    end else begin
      tx_meta_r <= i_tx_en;
      tx_en_s   <= tx_meta_r;
    end
  end

  assign mode10 = ~i_speed_100 & ~i_fiber_100_mode; // see [RQ14]

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_an_force_off  <= 1'b0;
      o_speed_100_rpt <= 1'b0;
    end else begin
      o_an_force_off  <= i_fiber_100_mode; // see [RQ21]
      o_speed_100_rpt <= i_speed_100 | i_fiber_100_mode; // see [RQ21]
    end
  end

  // --------------------------------------------------------------------------
  // Jabber timer: cut-off after long transmit, recovery after long idle
  // --------------------------------------------------------------------------
  logic [P_CNT_W-1:0] jab_cnt_r;
  logic               cut_r;
  logic               jab_event;
  logic               rec_hit;

  assign jab_event = mode10 & ~cut_r & tx_en_s & (jab_cnt_r >= L_JAB_CYC); // see [RQ15]
  assign rec_hit   = mode10 & cut_r & ~tx_en_s & (jab_cnt_r >= L_REC_CYC); // see [RQ16]

  always_ff @(posedge i_clk) begin
    if (i_rst || i_soft_rst || !mode10) begin
      jab_cnt_r <= '0;
      cut_r     <= 1'b0;
    end else if (jab_event) begin
      jab_cnt_r <= '0;
      cut_r     <= 1'b1; // see [RQ15]
    end else if (rec_hit) begin
      jab_cnt_r <= '0;
      cut_r     <= 1'b0; // see [RQ16]
    end else if (tx_en_s != cut_r) begin
      jab_cnt_r <= jab_cnt_r + P_CNT_W'(1'h1);
    end else begin
      jab_cnt_r <= '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_tx_inhibit       <= 1'b0;
      o_loopback_inhibit <= 1'b0;
    end else begin
      o_tx_inhibit       <= cut_r; // see [RQ15]
      o_loopback_inhibit <= cut_r; // see [RQ15]
    end
  end

  // --------------------------------------------------------------------------
  // Collision LED blink while cut off
  // --------------------------------------------------------------------------
  logic [P_CNT_W-1:0] blink_cnt_r;

  always_ff @(posedge i_clk) begin
    if (i_rst || !cut_r) begin
      blink_cnt_r               <= '0;
      o_collision_indicator_led <= 1'b0; // see [RQ16]
    end else if (blink_cnt_r >= L_BLINK_CYC) begin
      blink_cnt_r               <= '0;
      o_collision_indicator_led <= ~o_collision_indicator_led; // see [RQ15]
    end else begin
      blink_cnt_r <= blink_cnt_r + P_CNT_W'(1'h1);
    end
  end

  // --------------------------------------------------------------------------
  // Latched status bits; an event in the clearing cycle wins
  // --------------------------------------------------------------------------
  logic rf_r;
  logic fail_r;
  logic jab_r;
  logic link_prev_r;
  logic link_drop;
  logic snap_rf_r;
  logic snap_fail_r;
  logic snap_jab_r;
  logic clr_rd;

  assign link_drop = link_prev_r & ~i_link_pass;
  assign clr_rd    = rd_done && (rd_reg == psir_pkg::REG_STATUS); // see [RQ22]

  // Only what the finished read actually reported gets cleared
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      snap_rf_r   <= 1'b0;
      snap_fail_r <= 1'b0;
      snap_jab_r  <= 1'b0;
    end else if (rd_load && rd_reg == psir_pkg::REG_STATUS) begin
      snap_rf_r   <= rf_r;
      snap_fail_r <= fail_r;
      snap_jab_r  <= jab_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || i_soft_rst) begin
      rf_r        <= 1'b0;
      fail_r      <= 1'b0;
      jab_r       <= 1'b0;
      link_prev_r <= 1'b0;
    end else begin
      link_prev_r <= i_link_pass;
      rf_r        <= i_far_end_fault | (rf_r & ~(clr_rd & snap_rf_r)); // see [RQ9] [RQ10]
      fail_r      <= link_drop | (fail_r & ~(clr_rd & snap_fail_r)); // see [RQ13]
      jab_r       <= jab_event | (jab_r & ~(clr_rd & snap_jab_r)); // see [RQ14]
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  always_comb begin
    rd_word = 16'h0000;
    if (rd_reg == psir_pkg::REG_STATUS) begin
      rd_word[`PSIR_ST_T4]                     = `PSIR_T4_VAL; // see [RQ1]
      rd_word[`PSIR_ST_CAP_HI:`PSIR_ST_CAP_LO] = `PSIR_CAP_VAL; // see [RQ2]
      rd_word[`PSIR_ST_RSV_HI:`PSIR_ST_RSV_LO] = `PSIR_RSV_VAL; // see [RQ3]
      rd_word[`PSIR_ST_PRE]                    = `PSIR_PRE_VAL; // see [RQ4]
      rd_word[`PSIR_ST_ANC]  = i_an_complete & ~i_fiber_100_mode; // see [RQ8] [RQ21]
      rd_word[`PSIR_ST_RF]   = rf_r; // see [RQ9]
      rd_word[`PSIR_ST_ANA]  = `PSIR_ANA_VAL; // see [RQ11]
      rd_word[`PSIR_ST_LINK] = i_link_pass & ~fail_r; // see [RQ12] [RQ13]
      rd_word[`PSIR_ST_JAB]  = jab_r; // see [RQ14]
      rd_word[`PSIR_ST_EXT]  = `PSIR_EXT_VAL; // see [RQ17]
    end else if (rd_reg == psir_pkg::REG_ID1) begin
      rd_word = P_OUI_ID1; // see [RQ18] [RQ19]
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic st_load;
  assign st_load = rd_load && (rd_reg == psir_pkg::REG_STATUS);

  a_t4_zero: // see [RQ1]
    assert property (st_load |-> rd_word[15] == 1'b0)
      else $error("four-pair flag read as one");
  a_cap_ones: // see [RQ2]
    assert property (st_load |-> rd_word[14:11] == 4'hF)
      else $error("capability bits not all one");
  a_rsvd_zero: // see [RQ3]
    assert property (st_load |-> rd_word[10:7] == 4'h0)
      else $error("reserved bits not zero");
  a_fixed_ones: // see [RQ4]
    assert property (st_load |-> rd_word[6] && rd_word[3] && rd_word[0])
      else $error("fixed one bits read zero");
  a_an_done: // see [RQ8]
    assert property (st_load |-> rd_word[5] == (i_an_complete && !i_fiber_100_mode))
      else $error("negotiation complete bit wrong");
  a_rf_latch: // see [RQ9]
    assert property (i_far_end_fault && !i_soft_rst |=> rf_r ##1
                     (rf_r || $past(clr_rd) || $past(i_soft_rst)))
      else $error("remote fault not latched");
  a_rf_clear_full: // see [RQ10]
    assert property ($fell(rf_r) |-> $past(clr_rd) || $past(i_soft_rst))
      else $error("remote fault cleared without complete read");
  a_link_fail: // see [RQ13]
    assert property (link_drop && !i_soft_rst |=> fail_r && !rd_word[2] ||
                     rd_reg != psir_pkg::REG_STATUS)
      else $error("link failure not latched low");
  a_jab_cut: // see [RQ15]
    assert property (jab_event && !i_soft_rst |=> cut_r ##1 o_tx_inhibit && o_loopback_inhibit)
      else $error("jabber cut-off not applied");
  a_jab_mode: // see [RQ14]
    assert property (!mode10 |=> !cut_r ##1 !o_tx_inhibit)
      else $error("jabber active in 100 Mb mode");
  a_jab_recover: // see [RQ16]
    assert property ($fell(cut_r) |-> !$past(tx_en_s) || !$past(mode10) || $past(i_soft_rst))
      else $error("transmit restored while transmit enable high");
  a_led_off: // see [RQ16]
    assert property (!cut_r |=> !o_collision_indicator_led)
      else $error("collision LED blinking without cut-off");
  a_id_word: // see [RQ18]
    assert property (rd_load && rd_reg == psir_pkg::REG_ID1 |-> rd_word == P_OUI_ID1)
      else $error("identifier word wrong");

  c_rf_cleared: cover property (rf_r ##1 !rf_r);
  c_jab_cut:    cover property (jab_event ##[1:4] o_tx_inhibit);
  c_link_read:  cover property (fail_r && clr_rd ##1 !fail_r);

endmodule // psir_status_regs
`default_nettype wire

// ---- verification/psir_mgmt_host.sv ----
// Management host model driving the clock and data pins of the status block
`timescale 1ns/10ps
`default_nettype none

module psir_mgmt_host (
  // Clock
  input  wire logic i_clk,
  // Device side of the data pin
  input  wire logic i_dev_out,
  input  wire logic i_dev_oe,
  // Pins seen by the device
  output logic      o_mdc,
  output logic      o_mdio
);
  logic host_oe;
  logic host_d;

  // Pull-up resolves the shared data wire
  assign o_mdio = (host_oe ? host_d : 1'h1) & (i_dev_oe ? i_dev_out : 1'h1);

  initial begin
    o_mdc = 1'h0;
    host_oe = 1'h1;
    host_d = 1'h1;
  end

  // One bit: data set with the clock low, sampled just before the clock rises
  task automatic put_bit(input logic d, input logic drv, output logic seen);
    @(posedge i_clk);
    o_mdc <= 1'h0;
    host_d <= d;
    host_oe <= drv;
    repeat (8) @(posedge i_clk);
    seen = o_mdio;
    o_mdc <= 1'h1;
    repeat (7) @(posedge i_clk);
  endtask

  // Whole frame, then one idle bit; nbits below 32 cuts the frame short before that idle bit
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, input int pre, input int nbits,
                       output logic [15:0] rd);
    logic [31:0] bits;
    logic        s;
    bits = {2'h1, op, phy, ra, 2'h2, wd};
    rd = 16'hFFFF;
    for (int i = 0; i < pre; i++) put_bit(1'h1, 1'h1, s);
    for (int i = 0; i < nbits; i++) begin
      put_bit(bits[31-i], (i < 14) || (op != 2'h2), s);
      if (i >= 16) rd[31-i] = s;
    end
    put_bit(1'h1, 1'h1, s);
  endtask
endmodule  // psir_mgmt_host

`default_nettype wire

// ---- verification/psir_status_regs_tb.sv ----
// Self-checking bench for the port status and first identifier registers
`timescale 1ns/10ps
`default_nettype none

module psir_status_regs_tb;
  localparam logic [15:0] id1_val = 16'hA5C3;  // Arbitrary identifier value
  logic        i_clk;
  logic        i_rst;
  logic        i_soft_rst;
  logic        i_link_pass;
  logic        i_an_complete;
  logic        i_far_end_fault;
  logic        i_speed_100;
  logic        i_fiber_100_mode;
  logic        i_tx_en;
  logic        mdc;
  logic        mdio;
  logic        dev_out;
  logic        dev_oe;
  logic        tx_inh;
  logic        lb_inh;
  logic        led;
  logic        an_off;
  logic        spd_rpt;
  logic        led_was;
  logic [15:0] rd;
  int          bad_count;
  int          n_checks;
  int          cyc;

  psir_status_regs #(
    .P_OUI_ID1(id1_val), .P_JABBER_CYC(40), .P_RECOVER_CYC(100), .P_BLINK_CYC(8)
  ) psir_status_regs_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_soft_rst(i_soft_rst), .i_mdc(mdc), .i_mdio_in(mdio),
    .o_mdio_out(dev_out), .o_mdio_oe(dev_oe), .i_link_pass(i_link_pass),
    .i_an_complete(i_an_complete), .i_far_end_fault(i_far_end_fault),
    .i_speed_100(i_speed_100), .i_fiber_100_mode(i_fiber_100_mode), .i_tx_en(i_tx_en),
    .o_tx_inhibit(tx_inh), .o_loopback_inhibit(lb_inh), .o_collision_indicator_led(led),
    .o_an_force_off(an_off), .o_speed_100_rpt(spd_rpt)
  );

  psir_mgmt_host psir_mgmt_host_inst (
    .i_clk(i_clk), .i_dev_out(dev_out), .i_dev_oe(dev_oe), .o_mdc(mdc), .o_mdio(mdio)
  );

  initial begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [4:0] phy, input logic [4:0] ra, input int pre,
                        input logic [15:0] exp, input string nm);
    psir_mgmt_host_inst.frame(2'h2, phy, ra, 16'h0000, pre, 32, rd);
    chk(nm, exp, rd);
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    {i_soft_rst, i_link_pass, i_an_complete, i_far_end_fault} = 4'h0;
    {i_speed_100, i_fiber_100_mode, i_tx_en} = 3'h0;
    i_rst = 1'h1;
    wait_clk(6);
    i_rst <= 1'h0;
    rd_chk(5'h00, 5'h01, 32, 16'h7849, "status");
    rd_chk(5'h00, 5'h02, 1, id1_val, "id1");
    rd_chk(5'h00, 5'h03, 1, 16'hFFFF, "unmapped");
    rd_chk(5'h01, 5'h01, 1, 16'hFFFF, "other phy");
    psir_mgmt_host_inst.frame(2'h1, 5'h00, 5'h01, 16'h0000, 1, 32, rd);
    rd_chk(5'h00, 5'h01, 1, 16'h7849, "after write");
    // Fault latch survives a cut-short frame, clears after a whole read
    i_far_end_fault <= 1'h1;
    wait_clk(1);
    i_far_end_fault <= 1'h0;
    psir_mgmt_host_inst.frame(2'h2, 5'h00, 5'h01, 16'h0000, 32, 8, rd);
    rd_chk(5'h00, 5'h01, 40, 16'h7859, "fault");
    rd_chk(5'h00, 5'h01, 1, 16'h7849, "fault read");
    i_far_end_fault <= 1'h1;
    wait_clk(1);
    i_far_end_fault <= 1'h0;
    i_soft_rst <= 1'h1;
    wait_clk(2);
    i_soft_rst <= 1'h0;
    rd_chk(5'h00, 5'h01, 1, 16'h7849, "soft reset");
    // Link pass, then a short failure latched low until read
    i_link_pass <= 1'h1;
    i_an_complete <= 1'h1;
    wait_clk(4);
    rd_chk(5'h00, 5'h01, 1, 16'h786D, "link up");
    i_link_pass <= 1'h0;
    wait_clk(3);
    i_link_pass <= 1'h1;
    wait_clk(3);
    rd_chk(5'h00, 5'h01, 1, 16'h7869, "link fail");
    rd_chk(5'h00, 5'h01, 1, 16'h786D, "link again");
    i_fiber_100_mode <= 1'h1;
    wait_clk(3);
    chk("an off", 16'h0001, {15'h0, an_off});
    chk("speed", 16'h0001, {15'h0, spd_rpt});
    rd_chk(5'h00, 5'h01, 1, 16'h784D, "fiber");
    i_fiber_100_mode <= 1'h0;
    // Long transmit at 100 Mb is not jabber
    i_speed_100 <= 1'h1;
    i_tx_en <= 1'h1;
    wait_clk(60);
    chk("inhibit 100", 16'h0000, {15'h0, tx_inh});
    i_tx_en <= 1'h0;
    i_speed_100 <= 1'h0;
    wait_clk(5);
    i_tx_en <= 1'h1;
    wait_clk(60);
    chk("inhibit", 16'h0001, {15'h0, tx_inh});
    chk("loop inhibit", 16'h0001, {15'h0, lb_inh});
    led_was = led;
    wait_clk(9);
    chk("led blink", {15'h0, ~led_was}, {15'h0, led});
    i_tx_en <= 1'h0;
    wait_clk(120);
    chk("restore", 16'h0000, {15'h0, tx_inh});
    chk("led off", 16'h0000, {15'h0, led});
    rd_chk(5'h00, 5'h01, 1, 16'h786F, "jabber");
    rd_chk(5'h00, 5'h01, 1, 16'h786D, "jabber read");
    wrap_up();
  end
endmodule  // psir_status_regs_tb

`default_nettype wire
